// *** rtl/rpsf_pkg.sv ***
// package: register map, field layout, reset values and timing constants for the ramp register bank
package rpsf_pkg;
    // register offsets
    localparam logic [7:0] off_ramp_phase_sync_config = 8'h6a;
    localparam logic [7:0] off_spread_mode_enables = 8'h6b;
    localparam logic [7:0] off_spread_range_settings = 8'h6c;
    localparam logic [7:0] off_manual_ramp_divisor = 8'h6d;
    localparam logic [7:0] off_triangle_step_sizes = 8'h6e;
    localparam logic [7:0] off_triangle_amplitude_boundary = 8'h6f;
    localparam logic [7:0] off_channel_fault_status = 8'h70;
    // reset values
    localparam logic [7:0] rst_ramp_phase_sync_config = 8'h00;
    localparam logic [7:0] rst_spread_mode_enables = 8'h00;
    localparam logic [7:0] rst_spread_range_settings = 8'h00;
    localparam logic [7:0] rst_manual_ramp_divisor = 8'h50;
    localparam logic [7:0] rst_triangle_step_sizes = 8'h11;
    localparam logic [7:0] rst_triangle_amplitude_boundary = 8'h24;
    localparam logic [7:0] rst_channel_fault_status = 8'h00;
    // field positions
    localparam int phase_sel_hi = 3;
    localparam int phase_sel_lo = 2;
    localparam int serial_sync_bit = 1;
    localparam int phase_sync_bit = 0;
    localparam int pre_div_bit = 5;
    localparam int manual_mode_bit = 4;
    localparam int random_en_bit = 1;
    localparam int triangle_en_bit = 0;
    localparam int random_range_hi = 6;
    localparam int random_range_lo = 4;
    localparam int triangle_ctrl_hi = 3;
    localparam int triangle_ctrl_lo = 0;
    localparam int fall_step_hi = 7;
    localparam int fall_step_lo = 4;
    localparam int rise_step_hi = 3;
    localparam int rise_step_lo = 0;
    localparam int amplitude_hi = 6;
    localparam int amplitude_lo = 5;
    localparam int boundary_hi = 4;
    localparam int boundary_lo = 0;
    localparam int left_dc_bit = 3;
    localparam int right_dc_bit = 2;
    localparam int left_oc_bit = 1;
    localparam int right_oc_bit = 0;
    // writable bit masks, and the fault status read mask: reserved bits read as zero
    localparam logic [7:0] mask_phase = 8'h0f;
    localparam logic [7:0] mask_modes = 8'h33;
    localparam logic [7:0] mask_range = 8'h7f;
    localparam logic [7:0] mask_amp = 8'h7f;
    localparam logic [7:0] mask_fault = 8'h0f;
    // manual ramp base frequency in hertz
    localparam int ramp_base_hz = 61440000;

    typedef enum logic [2:0] {
        rpsf_mod_fixed = 3'b001,
        rpsf_mod_random = 3'b010,
        rpsf_mod_triangle = 3'b100
    } rpsf_mod_t;

    // configuration handed to the ramp generator
    typedef struct packed {
        logic [1:0] phase_select;
        logic serial_sync_enable;
        logic phase_sync_enable;
        logic manual_mode;
        logic pre_divide_by_two;
        logic random_spread_enable;
        logic triangle_spread_enable;
        logic [2:0] random_spread_range;
        logic [3:0] triangle_spread_control;
        logic [7:0] manual_freq_divisor;
        logic [3:0] sweep_fall_step;
        logic [3:0] sweep_rise_step;
        logic [1:0] ramp_amplitude_setting;
        logic [4:0] sweep_boundary;
    } rpsf_cfg_t;

    typedef struct packed {
        logic left_dc_fault;
        logic right_dc_fault;
        logic left_overcurrent_fault;
        logic right_overcurrent_fault;
    } rpsf_fault_t;
endpackage : rpsf_pkg

// *** rtl/rpsf_regs.sv ***
// ramp phase, spread spectrum and channel fault register bank
module rpsf_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port from the control interface decoder
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // fault detector levels from the output stage, asynchronous
    input wire rpsf_pkg::rpsf_fault_t fault_in,
    // configuration and modulation mode to the ramp generator
    output rpsf_pkg::rpsf_cfg_t ramp_cfg,
    output rpsf_pkg::rpsf_mod_t mod_mode,
    output logic ramp_manual_active,
    output logic [31:0] manual_ramp_hz
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] ramp_phase_sync_config;
    logic [7:0] spread_mode_enables;
    logic [7:0] spread_range_settings;
    logic [7:0] manual_ramp_divisor;
    logic [7:0] triangle_step_sizes;
    logic [7:0] triangle_amplitude_boundary;
    logic [7:0] channel_fault_status;
    rpsf_pkg::rpsf_fault_t fault_meta;
    rpsf_pkg::rpsf_fault_t fault_sync;
    logic [7:0] next_rdata;
    logic next_hit;
    rpsf_pkg::rpsf_mod_t next_mod;

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    // phase choice takes effect at once; the host has to settle it before play starts
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ramp_phase_sync_config <= rpsf_pkg::rst_ramp_phase_sync_config;
        end else if (reg_write && reg_addr == rpsf_pkg::off_ramp_phase_sync_config) begin
            ramp_phase_sync_config <= reg_wdata & rpsf_pkg::mask_phase;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            spread_mode_enables <= rpsf_pkg::rst_spread_mode_enables;
        end else if (reg_write && reg_addr == rpsf_pkg::off_spread_mode_enables) begin
            spread_mode_enables <= reg_wdata & rpsf_pkg::mask_modes;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            spread_range_settings <= rpsf_pkg::rst_spread_range_settings;
        end else if (reg_write && reg_addr == rpsf_pkg::off_spread_range_settings) begin
            spread_range_settings <= reg_wdata & rpsf_pkg::mask_range;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            manual_ramp_divisor <= rpsf_pkg::rst_manual_ramp_divisor;
        end else if (reg_write && reg_addr == rpsf_pkg::off_manual_ramp_divisor) begin
            manual_ramp_divisor <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            triangle_step_sizes <= rpsf_pkg::rst_triangle_step_sizes;
        end else if (reg_write && reg_addr == rpsf_pkg::off_triangle_step_sizes) begin
            triangle_step_sizes <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            triangle_amplitude_boundary <= rpsf_pkg::rst_triangle_amplitude_boundary;
        end else if (reg_write && reg_addr == rpsf_pkg::off_triangle_amplitude_boundary) begin
            triangle_amplitude_boundary <= reg_wdata & rpsf_pkg::mask_amp;
        end
    end

    // ----------------------------------------
    // fault status
    // ----------------------------------------
    // detector levels come from analog comparators, so two flops before use
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_meta <= '0;
            fault_sync <= '0;
        end else begin
            fault_meta <= fault_in;
            fault_sync <= fault_meta;
        end
    end

    // status follows the live level; latching and clearing live elsewhere
    always_ff @(posedge core_clk) begin
        if (reset) begin
            channel_fault_status <= rpsf_pkg::rst_channel_fault_status;
        end else begin
            channel_fault_status <= '0;
            channel_fault_status[rpsf_pkg::left_dc_bit] <= fault_sync.left_dc_fault;
            channel_fault_status[rpsf_pkg::right_dc_bit] <= fault_sync.right_dc_fault;
            channel_fault_status[rpsf_pkg::left_oc_bit] <= fault_sync.left_overcurrent_fault;
            channel_fault_status[rpsf_pkg::right_oc_bit] <= fault_sync.right_overcurrent_fault;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb begin
        next_hit = 1'b1;
        case (reg_addr)
            rpsf_pkg::off_ramp_phase_sync_config: next_rdata = ramp_phase_sync_config;
            rpsf_pkg::off_spread_mode_enables: next_rdata = spread_mode_enables;
            rpsf_pkg::off_spread_range_settings: next_rdata = spread_range_settings;
            rpsf_pkg::off_manual_ramp_divisor: next_rdata = manual_ramp_divisor;
            rpsf_pkg::off_triangle_step_sizes: next_rdata = triangle_step_sizes;
            rpsf_pkg::off_triangle_amplitude_boundary: next_rdata = triangle_amplitude_boundary;
            rpsf_pkg::off_channel_fault_status: next_rdata = channel_fault_status & rpsf_pkg::mask_fault;
            default: begin
                next_rdata = '0;
                next_hit = 1'b0;
            end
        endcase
    end

    // read data registered one cycle after the strobe; unmapped offsets answer zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= '0;
            reg_hit <= 1'b0;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
            reg_hit <= next_hit;
        end
    end

    // ----------------------------------------
    // configuration out
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ramp_cfg <= '0;
        end else begin
            ramp_cfg.phase_select <= ramp_phase_sync_config[rpsf_pkg::phase_sel_hi:rpsf_pkg::phase_sel_lo];
            ramp_cfg.serial_sync_enable <= ramp_phase_sync_config[rpsf_pkg::serial_sync_bit];
            ramp_cfg.phase_sync_enable <= ramp_phase_sync_config[rpsf_pkg::phase_sync_bit];
            ramp_cfg.manual_mode <= spread_mode_enables[rpsf_pkg::manual_mode_bit];
            ramp_cfg.pre_divide_by_two <= spread_mode_enables[rpsf_pkg::manual_mode_bit]
                & spread_mode_enables[rpsf_pkg::pre_div_bit];
            ramp_cfg.random_spread_enable <= spread_mode_enables[rpsf_pkg::random_en_bit];
            ramp_cfg.triangle_spread_enable <= spread_mode_enables[rpsf_pkg::triangle_en_bit];
            ramp_cfg.random_spread_range <=
                spread_range_settings[rpsf_pkg::random_range_hi:rpsf_pkg::random_range_lo];
            ramp_cfg.triangle_spread_control <=
                spread_range_settings[rpsf_pkg::triangle_ctrl_hi:rpsf_pkg::triangle_ctrl_lo];
            ramp_cfg.manual_freq_divisor <= manual_ramp_divisor;
            ramp_cfg.sweep_fall_step <= triangle_step_sizes[rpsf_pkg::fall_step_hi:rpsf_pkg::fall_step_lo];
            ramp_cfg.sweep_rise_step <= triangle_step_sizes[rpsf_pkg::rise_step_hi:rpsf_pkg::rise_step_lo];
            ramp_cfg.ramp_amplitude_setting <=
                triangle_amplitude_boundary[rpsf_pkg::amplitude_hi:rpsf_pkg::amplitude_lo];
            ramp_cfg.sweep_boundary <=
                triangle_amplitude_boundary[rpsf_pkg::boundary_hi:rpsf_pkg::boundary_lo];
        end
    end

    assign ramp_manual_active = ramp_cfg.manual_mode;

    // both enables set: triangle takes precedence as the deterministic sweep
    always_comb begin
        if (spread_mode_enables[rpsf_pkg::triangle_en_bit]) begin
            next_mod = rpsf_pkg::rpsf_mod_triangle;
        end else if (spread_mode_enables[rpsf_pkg::random_en_bit]) begin
            next_mod = rpsf_pkg::rpsf_mod_random;
        end else begin
            next_mod = rpsf_pkg::rpsf_mod_fixed;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mod_mode <= rpsf_pkg::rpsf_mod_fixed;
        end else begin
            case (next_mod)
                rpsf_pkg::rpsf_mod_random: mod_mode <= rpsf_pkg::rpsf_mod_random;
                rpsf_pkg::rpsf_mod_triangle: mod_mode <= rpsf_pkg::rpsf_mod_triangle;
                default: mod_mode <= rpsf_pkg::rpsf_mod_fixed;
            endcase
        end
    end

    // divisor of zero is not meaningful; report zero rather than divide by it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            manual_ramp_hz <= '0;
        end else if (manual_ramp_divisor == 8'h00) begin
            manual_ramp_hz <= '0;
        end else begin
            manual_ramp_hz <= 32'(rpsf_pkg::ramp_base_hz) / {24'h000000, manual_ramp_divisor};
        end
    end
endmodule : rpsf_regs

// *** sim/rpsf_regs_properties.sv ***
// checker for the ramp register bank ports
module rpsf_regs_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // faults and ramp outputs
    input wire rpsf_pkg::rpsf_fault_t fault_in,
    input wire rpsf_pkg::rpsf_cfg_t ramp_cfg,
    input wire rpsf_pkg::rpsf_mod_t mod_mode,
    input wire logic ramp_manual_active,
    input wire logic [31:0] manual_ramp_hz
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // ----
    // config copies land two edges after the write
    // ----
    sequence s_wr(logic [7:0] a);
        reg_write && reg_addr == a;
    endsequence
    // fault level must be stable long enough to cross the synchroniser
    sequence s_fault_read;
        $stable(fault_in) [*5] ##0 reg_read && reg_addr == rpsf_pkg::off_channel_fault_status;
    endsequence
    AST_PHASE: assert property (s_wr(rpsf_pkg::off_ramp_phase_sync_config) |-> ##2
        ramp_cfg.phase_select == $past(reg_wdata[3:2], 2)) else $error("phase select wrong");
    AST_SYNC: assert property (s_wr(rpsf_pkg::off_ramp_phase_sync_config) |-> ##2
        {ramp_cfg.serial_sync_enable, ramp_cfg.phase_sync_enable} == $past(reg_wdata[1:0], 2))
        else $error("sync enables wrong");
    AST_MODE: assert property (s_wr(rpsf_pkg::off_spread_mode_enables) |-> ##2
        ramp_cfg.manual_mode == $past(reg_wdata[4], 2)
        && ramp_cfg.pre_divide_by_two == $past(reg_wdata[5] & reg_wdata[4], 2)
        && {ramp_cfg.random_spread_enable, ramp_cfg.triangle_spread_enable} == $past(reg_wdata[1:0], 2)
        && mod_mode == ($past(reg_wdata[0], 2) ? rpsf_pkg::rpsf_mod_triangle : $past(reg_wdata[1], 2)
        ? rpsf_pkg::rpsf_mod_random : rpsf_pkg::rpsf_mod_fixed)) else $error("spread mode wrong");
    AST_RANGE: assert property (s_wr(rpsf_pkg::off_spread_range_settings) |-> ##2
        {ramp_cfg.random_spread_range, ramp_cfg.triangle_spread_control} == $past(reg_wdata[6:0], 2))
        else $error("spread range wrong");
    AST_DIV: assert property (s_wr(rpsf_pkg::off_manual_ramp_divisor) |-> ##2
        ramp_cfg.manual_freq_divisor == $past(reg_wdata, 2)) else $error("divisor wrong");
    AST_HZ: assert property (ramp_cfg.manual_freq_divisor != 8'h00 |->
        manual_ramp_hz == rpsf_pkg::ramp_base_hz / ramp_cfg.manual_freq_divisor) else $error("ramp hz wrong");
    AST_STEPS: assert property (s_wr(rpsf_pkg::off_triangle_step_sizes) |-> ##2
        {ramp_cfg.sweep_fall_step, ramp_cfg.sweep_rise_step} == $past(reg_wdata, 2)) else $error("steps wrong");
    AST_AMP: assert property (s_wr(rpsf_pkg::off_triangle_amplitude_boundary) |-> ##2
        {ramp_cfg.ramp_amplitude_setting, ramp_cfg.sweep_boundary} == $past(reg_wdata[6:0], 2))
        else $error("amplitude wrong");
    AST_FAULT: assert property (s_fault_read |=> reg_hit && reg_rdata == {4'h0, $past(fault_in)})
        else $error("fault status wrong");
    AST_UNMAPPED: assert property (reg_read && (reg_addr < rpsf_pkg::off_ramp_phase_sync_config
        || reg_addr > rpsf_pkg::off_channel_fault_status) |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read answered");
    AST_MANUAL: assert property (s_wr(rpsf_pkg::off_spread_mode_enables) |-> ##2
        ramp_manual_active == $past(reg_wdata[4], 2)) else $error("manual flag wrong");
endmodule : rpsf_regs_properties

bind rpsf_regs rpsf_regs_properties u_props (.core_clk(core_clk), .reset(reset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .fault_in(fault_in), .ramp_cfg(ramp_cfg), .mod_mode(mod_mode), .ramp_manual_active(ramp_manual_active),
    .manual_ramp_hz(manual_ramp_hz));

// *** sim/rpsf_regs_tb.sv ***
// self-checking testbench for the ramp register bank
module rpsf_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, reg_write, reg_read, reg_hit, ramp_manual_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [31:0] manual_ramp_hz;
    rpsf_pkg::rpsf_fault_t fault_in;
    rpsf_pkg::rpsf_cfg_t ramp_cfg;
    rpsf_pkg::rpsf_mod_t mod_mode;
    int failures = 0;
    int checked = 0;
    logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h50, 8'h11, 8'h24, 8'h00};
    logic [7:0] mode_tab [7] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h30, 8'h20, 8'hcc};
    rpsf_regs DUT (.core_clk(core_clk), .reset(reset), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .fault_in(fault_in),
        .ramp_cfg(ramp_cfg), .mod_mode(mod_mode), .ramp_manual_active(ramp_manual_active),
        .manual_ramp_hz(manual_ramp_hz));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ----
    // shared tasks
    // ----
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // write then wait until the config copy has landed
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_write <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        check("read data", {24'h0, reg_rdata}, {24'h0, exp});
        check("read hit", {31'h0, reg_hit}, {31'h0, hit});
    endtask : rd
    // ----
    // scenarios
    // ----
    task automatic test_reset();
        for (int i = 0; i < 7; i++) rd(8'h6a + 8'(i), rst_tab[i], 1'b1);
        check("reset hz", manual_ramp_hz, rpsf_pkg::ramp_base_hz / 80);
        check("reset steps", {24'h0, ramp_cfg.sweep_fall_step, ramp_cfg.sweep_rise_step}, 32'h11);
        check("reset mode", {29'h0, mod_mode}, {29'h0, rpsf_pkg::rpsf_mod_fixed});
        $display("test_reset done");
    endtask : test_reset
    task automatic test_phase();
        for (int p = 0; p < 4; p++) begin
            d = {6'h0, p[1:0]};
            wr(8'h6a, {4'hf, d[1:0], d[0], ~d[0]});
            check("phase", {30'h0, ramp_cfg.phase_select}, {30'h0, d[1:0]});
            check("sync", {30'h0, ramp_cfg.serial_sync_enable, ramp_cfg.phase_sync_enable},
                {30'h0, d[0], ~d[0]});
            rd(8'h6a, {4'h0, d[1:0], d[0], ~d[0]}, 1'b1);
        end
        $display("test_phase done");
    endtask : test_phase
    task automatic test_modes();
        for (int i = 0; i < 7; i++) begin
            d = mode_tab[i];
            wr(8'h6b, d);
            check("manual", {31'h0, ramp_manual_active}, {31'h0, d[4]});
            check("prediv", {31'h0, ramp_cfg.pre_divide_by_two}, {31'h0, d[5] & d[4]});
            check("enables", {30'h0, ramp_cfg.random_spread_enable, ramp_cfg.triangle_spread_enable},
                {30'h0, d[1:0]});
            check("mode", {29'h0, mod_mode}, d[0] ? 32'h4 : d[1] ? 32'h2 : 32'h1);
            rd(8'h6b, d & 8'h33, 1'b1);
        end
        $display("test_modes done");
    endtask : test_modes
    task automatic test_fields();
        wr(8'h6c, 8'hff);
        check("range", {25'h0, ramp_cfg.random_spread_range, ramp_cfg.triangle_spread_control}, 32'h7f);
        wr(8'h6e, 8'ha5);
        check("steps", {24'h0, ramp_cfg.sweep_fall_step, ramp_cfg.sweep_rise_step}, 32'ha5);
        wr(8'h6f, 8'hc1);
        check("amp", {25'h0, ramp_cfg.ramp_amplitude_setting, ramp_cfg.sweep_boundary}, 32'h41);
        rd(8'h6f, 8'h41, 1'b1);
        foreach (mode_tab[i]) begin
            d = mode_tab[i] + 8'h07;
            wr(8'h6d, d);
            check("hz", manual_ramp_hz, rpsf_pkg::ramp_base_hz / d);
        end
        wr(8'h6d, 8'h00);
        check("hz zero", manual_ramp_hz, 32'h0);
        $display("test_fields done");
    endtask : test_fields
    task automatic test_fault();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            fault_in <= rpsf_pkg::rpsf_fault_t'(4'h1 << i);
            repeat (6) @(posedge core_clk);
            rd(8'h70, 8'h01 << i, 1'b1);
        end
        wr(8'h70, 8'hff);
        rd(8'h70, 8'h08, 1'b1);
        rd(8'h69, 8'h00, 1'b0);
        rd(8'h71, 8'h00, 1'b0);
        $display("test_fault done");
    endtask : test_fault
    initial begin
        reset = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fault_in = '0;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        test_reset();
        test_phase();
        test_modes();
        test_fields();
        test_fault();
        report_and_stop();
    end
    initial begin
        #20000;
        failures++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule : rpsf_regs_tb
